// ==== core/rdr_refresh.sv ====
// display refresh engine with rotated scan order, colour lookup and panel timing
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
// What this block does
// - hardware rotates panel image 90/180/270 counter-clockwise
// - host buffer addresses never translated; refresh only
// - rotation 01 gives 90, order B D A C
// - rotation 10 gives 180, order D C B A
// - rotation 11 gives 270, order C A D B
// - horizontal total is (field plus one) times eight
// - vertical total is field plus one lines
// - monochrome below sixteen bpp uses only the green lookup table
// - sixteen bpp bypasses the lookup tables
// - inversion applied after the lookup stage
module rdr_refresh #(
    parameter int PIX_DIV = rdr_pkg::PCLK_DIV
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic rd_req_o,
    output logic [rdr_pkg::START_W-1:0] rd_addr_o,
    input wire logic rd_ack_i,
    input wire logic [31:0] rd_data_i,
    output logic panel_pix_en_o,
    output logic panel_de_o,
    output logic panel_hsync_o,
    output logic panel_vsync_o,
    output logic [rdr_pkg::RGB_W-1:0] panel_rgb_o
);
    import rdr_pkg::*;

    generate
        if (PIX_DIV < 2 || PIX_DIV > 255) begin : g_bad_div
            $error("pixel divider must lie between 2 and 255");
        end
    endgenerate

    // bits per pixel of a depth code
    function automatic logic signed [23:0] bpp_bits(input logic [2:0] code);
        case (code)
            BPP_1: return 24'sh000001;
            BPP_2: return 24'sh000002;
            BPP_4: return 24'sh000004;
            BPP_8: return 24'sh000008;
            default: return 24'sh000010;
        endcase
    endfunction

    // pixel taken from a fetched word, lowest bits hold the first pixel
    function automatic logic [15:0] extract(input logic [31:0] w, input logic [4:0] sh,
                                            input logic [2:0] code);
        logic [31:0] s;
        s = w >> sh;
        case (code)
            BPP_1: return {15'h0000, s[0]};
            BPP_2: return {14'h0000, s[1:0]};
            BPP_4: return {12'h000, s[3:0]};
            BPP_8: return {8'h00, s[7:0]};
            default: return s[15:0];
        endcase
    endfunction

    // registers
    logic [1:0] rot;
    logic [2:0] bpp;
    logic mono;
    logic inv;
    logic en;
    logic [HT_W-1:0] ht;
    logic [VT_W-1:0] vt;
    logic [DIM_W-1:0] wid;
    logic [DIM_W-1:0] hgt;
    logic [START_W-1:0] start;
    logic [OFFSET_W-1:0] offset;
    logic underrun;
    logic [7:0] lut_r [256];
    logic [7:0] lut_g [256];
    logic [7:0] lut_b [256];

    logic bus_req;
    logic bus_wr;
    logic lut_hit;
    logic [7:0] lut_idx;
    logic [31:0] reg_rdata;
    logic [31:0] wmerged;
    logic [9:0] v_count;
    logic [9:0] h_count;
    rdr_fetch_e fstate;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i;
    assign lut_hit = (wb_adr_i[11:10] == LUT_BASE[11:10]);
    assign lut_idx = wb_adr_i[9:2];

    // read decode, unmapped offsets read as zero
    always_comb begin
        reg_rdata = 32'h0000_0000;
        if (lut_hit) begin
            reg_rdata = {8'h00, lut_r[lut_idx], lut_g[lut_idx], lut_b[lut_idx]};
        end else begin
            case ({wb_adr_i[11:2], 2'h0})
                REG_CTRL: begin
                    reg_rdata[CTRL_ROT_LSB +: 2] = rot;
                    reg_rdata[CTRL_BPP_LSB +: 3] = bpp;
                    reg_rdata[CTRL_MONO_BIT] = mono;
                    reg_rdata[CTRL_INV_BIT] = inv;
                    reg_rdata[CTRL_EN_BIT] = en;
                end
                REG_HTOTAL: reg_rdata[HT_W-1:0] = ht;
                REG_VTOTAL: reg_rdata[VT_W-1:0] = vt;
                REG_SIZE: reg_rdata = {6'h00, hgt, 6'h00, wid};
                REG_START: reg_rdata[START_W-1:0] = start;
                REG_OFFSET: reg_rdata[OFFSET_W-1:0] = offset;
                REG_STATUS: begin
                    reg_rdata[STAT_UNDER_BIT] = underrun;
                    reg_rdata[STAT_BUSY_BIT] = (fstate != FS_IDLE);
                    reg_rdata[STAT_LINE_LSB +: 10] = v_count;
                end
                default: reg_rdata = 32'h0000_0000;
            endcase
        end
    end

    // byte lanes not selected keep their old contents
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmerged[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8] : reg_rdata[i*8 +: 8];
        end
    end

    // single-cycle acknowledge, one wait state, every address answered
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req) wb_dat_o <= wb_we_i ? 32'h0000_0000 : reg_rdata;
        end
    end

    // control and timing registers; rotation only steers the refresh fetch
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rot <= ROT_0;
            bpp <= BPP_1;
            mono <= 1'b0;
            inv <= 1'b0;
            en <= 1'b0;
            ht <= HTOTAL_RST;
            vt <= VTOTAL_RST;
            wid <= WID_RST;
            hgt <= HGT_RST;
            start <= '0;
            offset <= '0;
        end else if (bus_wr && !lut_hit) begin
            case ({wb_adr_i[11:2], 2'h0})
                REG_CTRL: begin
                    rot <= wmerged[CTRL_ROT_LSB +: 2];
                    bpp <= wmerged[CTRL_BPP_LSB +: 3];
                    mono <= wmerged[CTRL_MONO_BIT];
                    inv <= wmerged[CTRL_INV_BIT];
                    en <= wmerged[CTRL_EN_BIT];
                end
                REG_HTOTAL: ht <= wmerged[HT_W-1:0];
                REG_VTOTAL: vt <= wmerged[VT_W-1:0];
                REG_SIZE: begin
                    wid <= wmerged[DIM_W-1:0];
                    hgt <= wmerged[SIZE_HGT_LSB +: DIM_W];
                end
                REG_START: start <= wmerged[START_W-1:0];
                REG_OFFSET: offset <= wmerged[OFFSET_W-1:0];
                default: ;
            endcase
        end
    end

    // lookup table storage, written only from the bus
    always_ff @(posedge clock_i) begin
        if (bus_wr && lut_hit) begin
            lut_r[lut_idx] <= wmerged[23:16];
            lut_g[lut_idx] <= wmerged[15:8];
            lut_b[lut_idx] <= wmerged[7:0];
        end
    end

    // ---- refresh fetch engine ----
    logic [1:0] f_rot;
    logic [2:0] f_bpp;
    logic f_mono;
    logic f_inv;
    logic [DIM_W-1:0] f_wid;
    logic [DIM_W-1:0] f_hgt;
    logic [DIM_W-1:0] fx;
    logic [DIM_W-1:0] fy;
    logic signed [23:0] pix_addr;
    logic signed [23:0] line_addr;
    logic signed [23:0] next_pix_addr;
    logic signed [23:0] pitch;
    logic signed [23:0] step_x;
    logic signed [23:0] step_y;
    logic signed [23:0] origin;
    logic signed [23:0] f_bits;
    logic [15:0] raw;
    logic [RGB_W-1:0] colour;
    logic in_ready;
    logic in_valid;
    logic out_valid;
    logic [RGB_W-1:0] out_data;
    logic pop;
    logic eol;
    logic eof;

    assign pitch = {9'h000, offset, 5'h00};
    assign f_bits = bpp_bits(f_bpp);
    assign eol = (fx == f_wid);
    assign eof = eol && (fy == f_hgt);
    assign in_valid = (fstate == FS_PUSH);

    // scan steps per rotation: along a panel line and between lines
    always_comb begin
        case (f_rot)
            ROT_90: begin
                step_x = pitch;
                step_y = -f_bits;
            end
            ROT_180: begin
                step_x = -f_bits;
                step_y = -pitch;
            end
            ROT_270: begin
                step_x = -pitch;
                step_y = f_bits;
            end
            default: begin
                step_x = f_bits;
                step_y = pitch;
            end
        endcase
    end

    // first pixel: corner B and D sit in the last bits of their word
    always_comb begin
        origin = {2'h0, start, 5'h00};
        if (rot == ROT_90 || rot == ROT_180) begin
            origin = {2'h0, start, 5'h00} + 24'sh000020 - bpp_bits(bpp);
        end
    end

    assign next_pix_addr = eol ? line_addr + step_y : pix_addr + step_x;

    // frame restart latches rotation, depth, mono, inversion and size and begins at the start address
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fstate <= FS_IDLE;
            rd_req_o <= 1'b0;
            rd_addr_o <= '0;
            raw <= 16'h0000;
            fx <= '0;
            fy <= '0;
            pix_addr <= 24'sh000000;
            line_addr <= 24'sh000000;
            f_rot <= ROT_0;
            f_bpp <= BPP_1;
            f_mono <= 1'b0;
            f_inv <= 1'b0;
            f_wid <= '0;
            f_hgt <= '0;
        end else begin
            case (fstate)
                FS_IDLE: if (en) begin
                    f_rot <= rot;
                    f_bpp <= bpp;
                    f_mono <= mono;
                    f_inv <= inv;
                    f_wid <= wid;
                    f_hgt <= hgt;
                    fx <= '0;
                    fy <= '0;
                    pix_addr <= origin;
                    line_addr <= origin;
                    rd_addr_o <= origin[21:5];
                    rd_req_o <= 1'b1;
                    fstate <= FS_REQ;
                end
                // the request is held stable until the memory answers
                FS_REQ: if (rd_ack_i) begin
                    rd_req_o <= 1'b0;
                    raw <= extract(rd_data_i, pix_addr[4:0], f_bpp);
                    fstate <= FS_PUSH;
                end
                FS_PUSH: if (!en) begin
                    fstate <= FS_IDLE;
                end else if (in_ready) begin
                    if (eof) begin
                        fstate <= FS_IDLE;
                    end else begin
                        fx <= eol ? '0 : fx + DIM_W'(1);
                        fy <= eol ? fy + DIM_W'(1) : fy;
                        if (eol) line_addr <= next_pix_addr;
                        pix_addr <= next_pix_addr;
                        rd_addr_o <= next_pix_addr[21:5];
                        rd_req_o <= 1'b1;
                        fstate <= FS_REQ;
                    end
                end
                default: fstate <= FS_IDLE;
            endcase
        end
    end

    // colour path: lookup or bypass, then inversion
    always_comb begin
        if (f_bpp == BPP_16) begin
            colour = f_mono ? {3{raw[10:5], 2'h0}}
                            : {raw[15:11], 3'h0, raw[10:5], 2'h0, raw[4:0], 3'h0};
        end else if (f_mono) begin
            colour = {3{lut_g[raw[7:0]]}};
        end else begin
            colour = {lut_r[raw[7:0]], lut_g[raw[7:0]], lut_b[raw[7:0]]};
        end
        colour = colour ^ {RGB_W{f_inv}};
    end

    rdr_pix_buffer #(
        .WIDTH(RGB_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .flush_i(!en),
        .in_valid_i(in_valid),
        .in_ready_o(in_ready),
        .in_data_i(colour),
        .out_valid_o(out_valid),
        .out_ready_i(pop),
        .out_data_o(out_data)
    );

    // ---- panel timing on the pixel enable ----
    logic [7:0] div_cnt;
    logic pix_en;
    logic primed;
    logic run;
    logic active;
    logic [9:0] h_last;

    // last pixel of a line is (field + 1) * 8 - 1
    assign h_last = {ht, 3'h7};
    assign run = en && primed;
    assign active = (h_count <= wid) && (v_count <= hgt);
    assign pop = pix_en && run && active;

    // divider gives one enable pulse per pixel period
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt <= 8'h00;
            pix_en <= 1'b0;
        end else begin
            pix_en <= (div_cnt == 8'(PIX_DIV - 1));
            div_cnt <= (div_cnt == 8'(PIX_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
        end
    end

    // timing waits for the first fetched pixel so frames start in step
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            primed <= 1'b0;
        end else if (!en) begin
            primed <= 1'b0;
        end else if (out_valid) begin
            primed <= 1'b1;
        end
    end

    // line counter wraps after field + 1 lines
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            h_count <= 10'h000;
            v_count <= 10'h000;
        end else if (!run) begin
            h_count <= 10'h000;
            v_count <= 10'h000;
        end else if (pix_en) begin
            h_count <= (h_count == h_last) ? 10'h000 : h_count + 10'h001;
            if (h_count == h_last) v_count <= (v_count == vt) ? 10'h000 : v_count + 10'h001;
        end
    end

    // panel pins, pixel enable updated every clock and the rest once per pixel; sync pulses in the last eight pixels or line
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            panel_pix_en_o <= 1'b0;
            panel_de_o <= 1'b0;
            panel_hsync_o <= 1'b0;
            panel_vsync_o <= 1'b0;
            panel_rgb_o <= '0;
        end else begin
            panel_pix_en_o <= pix_en && run;
            if (pix_en) begin
                panel_de_o <= run && active;
                panel_hsync_o <= run && (h_count[9:3] == ht);
                panel_vsync_o <= run && (v_count == vt);
                panel_rgb_o <= (pop && out_valid) ? out_data : '0;
            end
        end
    end

    // sticky underrun; a new underrun wins over a clear in the same cycle
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            underrun <= 1'b0;
        end else if (pop && !out_valid) begin
            underrun <= 1'b1;
        end else if (bus_wr && !lut_hit && {wb_adr_i[11:2], 2'h0} == REG_STATUS
                     && wb_sel_i[0] && wb_dat_i[STAT_UNDER_BIT]) begin
            underrun <= 1'b0;
        end
    end

    // ---- assertions ----
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_step;
        fstate == FS_PUSH && en && in_ready && !eol;
    endsequence
    sequence s_req_wait;
        rd_req_o && !rd_ack_i;
    endsequence

    property p_req_hold;
        s_req_wait |=> rd_req_o && $stable(rd_addr_o);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("fetch request changed");
    property p_rot0_step;
        s_step and f_rot == ROT_0 |=> pix_addr == $past(pix_addr) + $past(f_bits);
    endproperty
    a_rot0_step: assert property (p_rot0_step) else $error("landscape step wrong");
    property p_rot90_step;
        s_step and f_rot == ROT_90 |=> pix_addr == $past(pix_addr) + $past(pitch);
    endproperty
    a_rot90_step: assert property (p_rot90_step) else $error("90 step wrong");
    property p_rot180_step;
        s_step and f_rot == ROT_180 |=> pix_addr == $past(pix_addr) - $past(f_bits);
    endproperty
    a_rot180_step: assert property (p_rot180_step) else $error("180 step wrong");
    property p_rot270_step;
        s_step and f_rot == ROT_270 |=> pix_addr == $past(pix_addr) - $past(pitch);
    endproperty
    a_rot270_step: assert property (p_rot270_step) else $error("270 step wrong");
    property p_line_wrap;
        pix_en && run && h_count == {ht, 3'h7} |=> h_count == 10'h000;
    endproperty
    a_line_wrap: assert property (p_line_wrap) else $error("line length wrong");
    property p_frame_wrap;
        pix_en && run && h_count == h_last && v_count == vt |=> v_count == 10'h000;
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("frame length wrong");
    property p_mono_green;
        in_valid && f_mono && !f_inv && f_bpp != BPP_16 |-> colour == {3{lut_g[raw[7:0]]}};
    endproperty
    a_mono_green: assert property (p_mono_green) else $error("mono not green table");
    property p_bypass;
        in_valid && !f_mono && !f_inv && f_bpp == BPP_16
            |-> colour == {raw[15:11], 3'h0, raw[10:5], 2'h0, raw[4:0], 3'h0};
    endproperty
    a_bypass: assert property (p_bypass) else $error("16 bpp not bypassed");
    property p_invert;
        in_valid && f_inv && !f_mono && f_bpp != BPP_16
            |-> colour == ~{lut_r[raw[7:0]], lut_g[raw[7:0]], lut_b[raw[7:0]]};
    endproperty
    a_invert: assert property (p_invert) else $error("inversion misplaced");
endmodule

// ==== common/rdr_pkg.sv ====
// constants, register map and types of the rotated display refresh block
package rdr_pkg;
    // register byte offsets on the wishbone port
    localparam logic [11:0] REG_CTRL = 12'h010;
    localparam logic [11:0] REG_HTOTAL = 12'h020;
    localparam logic [11:0] REG_SIZE = 12'h024;
    localparam logic [11:0] REG_VTOTAL = 12'h030;
    localparam logic [11:0] REG_START = 12'h040;
    localparam logic [11:0] REG_OFFSET = 12'h044;
    localparam logic [11:0] REG_STATUS = 12'h048;
    localparam logic [11:0] LUT_BASE = 12'h400;
    // field positions
    localparam int CTRL_BPP_LSB = 0;
    localparam int CTRL_MONO_BIT = 3;
    localparam int CTRL_INV_BIT = 4;
    localparam int CTRL_EN_BIT = 5;
    localparam int CTRL_ROT_LSB = 16;
    localparam int SIZE_HGT_LSB = 16;
    localparam int STAT_UNDER_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_LINE_LSB = 16;
    // field widths
    localparam int HT_W = 7;
    localparam int VT_W = 10;
    localparam int DIM_W = 10;
    localparam int START_W = 17;
    localparam int OFFSET_W = 10;
    localparam int RGB_W = 24;
    // values after reset
    localparam logic [HT_W-1:0] HTOTAL_RST = 7'h09;
    localparam logic [VT_W-1:0] VTOTAL_RST = 10'h03f;
    localparam logic [DIM_W-1:0] WID_RST = 10'h03f;
    localparam logic [DIM_W-1:0] HGT_RST = 10'h02f;
    // rotation select codes
    localparam logic [1:0] ROT_0 = 2'h0;
    localparam logic [1:0] ROT_90 = 2'h1;
    localparam logic [1:0] ROT_180 = 2'h2;
    localparam logic [1:0] ROT_270 = 2'h3;
    // colour depth codes
    localparam logic [2:0] BPP_1 = 3'h0;
    localparam logic [2:0] BPP_2 = 3'h1;
    localparam logic [2:0] BPP_4 = 3'h2;
    localparam logic [2:0] BPP_8 = 3'h3;
    localparam logic [2:0] BPP_16 = 3'h4;
    // pixel clock derived from the 40 MHz system clock
    localparam int CLK_HZ = 40_000_000;
    localparam int PIX_HZ = 10_000_000;
    localparam int PCLK_DIV = CLK_HZ / PIX_HZ;
    localparam int BUF_DEPTH = 2;
    // refresh fetch engine states
    typedef enum logic [1:0] {FS_IDLE, FS_REQ, FS_PUSH} rdr_fetch_e;
endpackage

// ==== core/rdr_pix_buffer.sv ====
// small valid/ready pixel buffer between the fetch engine and the panel
`timescale 1ns/1ps
module rdr_pix_buffer #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 2
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
            $error("buffer depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] fill;
    logic push;
    logic pop;

    // honest full and empty from the fill count
    assign in_ready_o = (fill != DEPTH[PW:0]);
    assign out_valid_o = (fill != '0);
    assign out_data_o = store[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_ready_i && out_valid_o;

    // pointers and fill level; flush drops everything held
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else if (flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + PW'(1);
            if (pop) rd_ptr <= rd_ptr + PW'(1);
            if (push && !pop) fill <= fill + (PW+1)'(1);
            else if (pop && !push) fill <= fill - (PW+1)'(1);
        end
    end

    // storage needs no reset, validity lives in the fill count
    always_ff @(posedge clock_i) begin
        if (push) store[wr_ptr] <= in_data_i;
    end
endmodule

// ==== verif/rdr_mem_model.sv ====
// display buffer responder on the refresh fetch port
`timescale 1ns/1ps
module rdr_mem_model (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [1:0] delay_i,
    input wire logic rd_req_i,
    input wire logic [16:0] rd_addr_i,
    output logic rd_ack_o,
    output logic [31:0] rd_data_o
);
    logic [1:0] wait_cnt;
    // answer after delay_i waits; the data bus toggles between answers so stale data is not seen
    // slow answers stand for a memory side only just fast enough
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_ack_o <= 1'b0;
            rd_data_o <= 32'h0;
            wait_cnt <= 2'h0;
        end else if (rd_req_i && !rd_ack_o && wait_cnt >= delay_i) begin
            rd_ack_o <= 1'b1;
            rd_data_o <= {15'h0, rd_addr_i};
            wait_cnt <= 2'h0;
        end else begin
            rd_ack_o <= 1'b0;
            rd_data_o <= ~rd_data_o;
            wait_cnt <= (rd_req_i && wait_cnt != 2'h3) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule

// ==== verif/rdr_refresh_tb.sv ====
// self-checking bench for the rotated display refresh block
`timescale 1ns/1ps
module rdr_refresh_tb;
    import rdr_pkg::*;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cyc, stb, we, ack, rd_req, rd_ack, pix, de, hs, vs, hs_d, vs_d, hchk, harm, varm;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, mdat;
    logic [16:0] rd_addr, st, off, ss, so;
    logic [15:0] w;
    logic [23:0] lv;
    logic [23:0] px_q[$];
    logic [23:0] rgb;
    logic [1:0] dly;
    logic [31:0] wb_q[$];
    logic [16:0] ad_q[$];
    int errors = 0, compares = 0, cycles = 0, hcnt = 0, vcnt = 0;
    logic [11:0] ra[7] = '{REG_CTRL, REG_HTOTAL, REG_SIZE, REG_VTOTAL, REG_START, REG_OFFSET, 12'h100};
    logic [31:0] rv[7] = '{32'h0, 32'h9, 32'h002f003f, 32'h3f, 32'h0, 32'h0, 32'h0};

    rdr_refresh #(.PIX_DIV(4)) u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .rd_req_o(rd_req), .rd_addr_o(rd_addr),
        .rd_ack_i(rd_ack), .rd_data_i(mdat), .panel_pix_en_o(pix), .panel_de_o(de),
        .panel_hsync_o(hs), .panel_vsync_o(vs), .panel_rgb_o(rgb));
    rdr_mem_model u_mem (.clock_i(clock_i), .rst_b_i(rst_b_i), .delay_i(dly), .rd_req_i(rd_req),
        .rd_addr_i(rd_addr), .rd_ack_o(rd_ack), .rd_data_o(mdat));

    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // one classic cycle; holds everything until ack is sampled, then releases
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hf, d};
        do @(posedge clock_i); while (ack !== 1'b1);
        {cyc, stb} <= 2'b00;
    endtask

    // watcher: takes the oldest note whenever a result shows
    always @(posedge clock_i) begin
        cycles++;
        if (cycles > 12000) begin
            errors++;
            conclude();
        end
        if (ack === 1'b1 && !we && wb_q.size() > 0) chk(rdat, wb_q.pop_front());
        if (rd_req === 1'b1 && rd_ack === 1'b1 && ad_q.size() > 0) chk(rd_addr, ad_q.pop_front());
        if (pix === 1'b1) begin
            hcnt++;
            vcnt++;
            // a new run must not measure against a sync edge of the last run
            if (!hchk) {harm, varm} = 2'b00;
            if (px_q.size() > 0) chk(rgb, px_q.pop_front());
            if (hs && !hs_d) begin
                if (hchk && harm) chk(hcnt, 16);
                harm = hchk;
                hcnt = 0;
            end
            if (vs && !vs_d) begin
                if (hchk && varm) chk(vcnt, 48);
                varm = hchk;
                vcnt = 0;
            end
            {hs_d, vs_d} = {hs, vs};
        end
    end

    initial begin
        {cyc, stb, we, adr, sel, dat, dly} = '0;
        {hs_d, vs_d, hchk, harm, varm} = '0;
        void'($urandom(60497));
        st = 17'h100 + 17'($urandom_range(0, 255));
        off = 17'h10;
        repeat (12) @(posedge clock_i);
        rst_b_i <= 1'b1;
        // reset values and an unmapped place read back
        for (int i = 0; i < 7; i++) begin
            wb_q.push_back(rv[i]);
            wb(1'b0, ra[i], 32'h0);
        end
        wb(1'b1, REG_HTOTAL, 32'h1);
        wb(1'b1, REG_VTOTAL, 32'h2);
        wb(1'b1, REG_OFFSET, 32'(off));
        wb(1'b1, REG_START, 32'(st));
        wb_q.push_back(32'(st));
        wb(1'b0, REG_START, 32'h0);
        // two lookup entries whose three channels all differ
        wb(1'b1, LUT_BASE, 32'h00a5c33c);
        wb(1'b1, LUT_BASE + 12'h004, 32'h005a0ff0);
        wb_q.push_back(32'h005a0ff0);
        wb(1'b0, LUT_BASE + 12'h004, 32'h0);
        // rotations at 16 bpp, then 1 bpp mono and inverted colour unrotated
        for (int r = 0; r < 6; r++) begin
            hchk = 1'b0;
            wb(1'b1, REG_CTRL, 32'h0);
            // corner word of each rotation, words per line
            ss = st + (r == 1 ? 17'h17 : r == 2 ? 17'h5ff : r == 3 ? 17'h5e8 : 17'h0);
            so = (r == 1 || r == 3) ? 17'h18 : 17'h20;
            wb(1'b1, REG_START, 32'(ss));
            wb(1'b1, REG_OFFSET, 32'(so));
            repeat (20) @(posedge clock_i);
            dly <= 2'($urandom_range(0, 1));
            ad_q.push_back(ss);
            ad_q.push_back(r == 1 ? ss + so : r == 3 ? ss - so : ss);
            ad_q.push_back(r == 3 ? ss - 2 * so : r == 2 ? ss - 1 : r == 1 ? ss + 2 * so
                : r == 0 ? ss + 1 : ss);
            for (int k = 0; k < 16; k++) begin
                w = 16'(ss + 17'(k / 2));
                lv = st[k] ? 24'h5a0ff0 : 24'ha5c33c;
                if (r == 0) px_q.push_back(k % 2 ? 24'h0
                    : {w[15:11], 3'h0, w[10:5], 2'h0, w[4:0], 3'h0});
                if (r > 3) px_q.push_back(r == 4 ? {3{lv[15:8]}} : ~lv);
            end
            wb(1'b1, REG_CTRL, r < 4 ? {14'h0, 2'(r), 16'h0024} : r == 4 ? 32'h28 : 32'h30);
            repeat (50) @(posedge clock_i);
            hchk = 1'b1;
            repeat (600) @(posedge clock_i);
        end
        // a memory side only just fast enough must never starve the panel
        wb(1'b1, REG_CTRL, 32'h0);
        repeat (20) @(posedge clock_i);
        wb_q.push_back(32'h0);
        wb(1'b0, REG_STATUS, 32'h0);
        chk(32'(ad_q.size() + px_q.size()), 32'h0);
        conclude();
    end
endmodule
